// *** shared/usp_pkg.sv ***
package usp_pkg;

	// ==========================================================
	// Control register location and reset
	localparam logic [7:0] USP_CTRL_ADDR = 8'h98;
	// The unused bit 6 reads back as one; every other bit resets low
	localparam logic [7:0] USP_CTRL_RESET = 8'h40;
	localparam logic USP_UNUSED_LEVEL = 1'b1;

	// ==========================================================
	// Frame formats selected by the mode bit
	localparam logic USP_FMT_8BIT = 1'b0;
	localparam logic USP_FMT_9BIT = 1'b1;

	// ==========================================================
	// Bit timing on the 16x oversampling tick
	localparam logic [3:0] USP_TICKS_LAST = 4'hF;
	localparam logic [3:0] USP_SAMPLE_TICK = 4'h7;
	localparam logic [3:0] USP_LAST_DATA_BIT = 4'h7;

	// ==========================================================
	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic frame_format_select;
		logic unused;
		logic stop_check_multiproc_enable;
		logic receive_enable_bit;
		logic transmit_ninth_bit;
		logic receive_ninth_bit;
		logic transmit_complete_flag;
		logic receive_complete_flag;
	} usp_ctrl_s;

	// Special function register access from the core
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} usp_sfr_req_s;

	// One received frame
	typedef struct packed {
		logic [7:0] data;
		logic ninth;
		logic stop;
	} usp_rx_frame_s;

	typedef enum logic [2:0] {
		USP_TX_IDLE,
		USP_TX_START,
		USP_TX_DATA,
		USP_TX_NINTH,
		USP_TX_STOP
	} usp_tx_state_e;

	typedef enum logic [2:0] {
		USP_RX_IDLE,
		USP_RX_START,
		USP_RX_DATA,
		USP_RX_NINTH,
		USP_RX_STOP
	} usp_rx_state_e;

endpackage : usp_pkg

// *** rtl/usp_rx_engine.sv ***
`timescale 1ns/1ps
`default_nettype none

module usp_rx_engine (
	input wire logic mclk,
	input wire logic rst_sync_n,
	input wire logic rx_level,
	input wire logic baud_tick,
	input wire logic enable,
	input wire logic nine_bit,
	output logic frame_done,
	output usp_pkg::usp_rx_frame_s frame
);
	import usp_pkg::*;

	typedef struct packed {
		usp_rx_state_e st;
		logic [3:0] tcnt;
		logic [3:0] bcnt;
		logic [7:0] shift;
		logic ninth;
		logic done;
		logic armed;
		usp_rx_frame_s frame;
	} usp_rx_state_s;

	usp_rx_state_s rx_reg;
	usp_rx_state_s rx_next;

	// ==========================================================
	// Bit engine
	always_comb begin
		rx_next = rx_reg;
		rx_next.done = 1'b0;
		if (baud_tick && rx_reg.st != USP_RX_IDLE) begin
			rx_next.tcnt = rx_reg.tcnt + 4'h1;
		end
		case (rx_reg.st)
			USP_RX_IDLE: begin
				rx_next.tcnt = 4'h0;
				// Start needs a fall from a high line, so a low stop bit
				// still on the wire cannot open a false frame
				rx_next.armed = rx_level;
				if (enable && rx_reg.armed && !rx_level) begin
					rx_next.st = USP_RX_START;
				end
			end
			USP_RX_START: begin
				// Re-check mid start bit so a glitch does not start a frame
				if (baud_tick && rx_reg.tcnt == USP_SAMPLE_TICK) begin
					rx_next.tcnt = 4'h0;
					rx_next.bcnt = 4'h0;
					rx_next.st = rx_level ? USP_RX_IDLE : USP_RX_DATA;
				end
			end
			USP_RX_DATA: begin
				if (baud_tick && rx_reg.tcnt == USP_TICKS_LAST) begin
					rx_next.shift = {rx_level, rx_reg.shift[7:1]};
					rx_next.bcnt = rx_reg.bcnt + 4'h1;
					if (rx_reg.bcnt == USP_LAST_DATA_BIT) begin
						rx_next.st = nine_bit ? USP_RX_NINTH : USP_RX_STOP;
					end
				end
			end
			USP_RX_NINTH: begin
				if (baud_tick && rx_reg.tcnt == USP_TICKS_LAST) begin
					rx_next.ninth = rx_level;
					rx_next.st = USP_RX_STOP;
				end
			end
			USP_RX_STOP: begin
				if (baud_tick && rx_reg.tcnt == USP_TICKS_LAST) begin
					rx_next.frame.data = rx_reg.shift;
					rx_next.frame.ninth = rx_reg.ninth;
					rx_next.frame.stop = rx_level;
					rx_next.done = 1'b1;
					rx_next.st = USP_RX_IDLE;
				end
			end
			default: begin
				rx_next.st = USP_RX_IDLE;
			end
		endcase
		// A frame in flight is dropped once reception is switched off
		if (!enable) begin
			rx_next.st = USP_RX_IDLE; // RULE_04
			rx_next.done = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rx_reg <= '0;
		end else begin
			rx_reg <= rx_next;
		end
	end

	assign frame_done = rx_reg.done;
	assign frame = rx_reg.frame;

endmodule : usp_rx_engine

`default_nettype wire

// *** rtl/usp_serial_port_two.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01 - The mode bit picks an 8-bit frame at 0 and a 9-bit frame at 1.
// RULE_02 - With stop checking on, 8-bit frames flag only on a high stop bit.
// RULE_03 - With filtering on, 9-bit frames flag only on a high ninth bit.
// RULE_04 - Frames are received only while the receive enable bit is 1.
// RULE_05 - 9-bit frames send the written ninth bit; hardware never alters it.
// RULE_06 - In 8-bit frames the software ninth bit has no effect on the line.
// RULE_07 - Each frame loads the stored ninth bit: stop bit or ninth data bit.
// RULE_08 - Frame ends set flags for the interrupt; only software clears them.
module usp_serial_port_two (
	input wire logic mclk,
	input wire logic rst_n,
	input wire usp_pkg::usp_sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic baud_tick,
	input wire logic tx_start,
	input wire logic [7:0] tx_data,
	output logic tx_busy,
	output logic tx_pin,
	input wire logic rx_pin,
	output logic [7:0] rx_data,
	output logic rx_data_valid,
	input wire logic port_int_enable,
	output logic port_irq
);
	import usp_pkg::*;

	typedef struct packed {
		logic [2:0] rx_sync;
		logic rx_level;
		usp_ctrl_s ctrl;
		logic [7:0] rdata;
		usp_tx_state_e tx_st;
		logic [3:0] tcnt;
		logic [3:0] bcnt;
		logic [7:0] tx_shift;
		logic txd;
		logic busy;
		logic [7:0] rx_data;
		logic rx_valid;
		logic irq;
	} usp_top_state_s;

	usp_top_state_s top_reg;
	usp_top_state_s top_next;
	logic [1:0] rst_sync_reg;
	logic rst_sync_n;
	logic rx_done;
	usp_rx_frame_s rx_frame;
	logic rx_accept;
	logic ctrl_wr;
	logic tx_end;

	// ==========================================================
	// Reset release
	// Held two edges so the whole block leaves reset on one clean edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync_reg[1];

	// ==========================================================
	// Receiver
	usp_rx_engine u_rx (
		.mclk(mclk),
		.rst_sync_n(rst_sync_n),
		.rx_level(top_reg.rx_level),
		.baud_tick(baud_tick),
		.enable(top_reg.ctrl.receive_enable_bit), // RULE_04
		.nine_bit(top_reg.ctrl.frame_format_select == // RULE_01
			USP_FMT_9BIT),
		.frame_done(rx_done),
		.frame(rx_frame)
	);

	// Stop checking and address filtering share one enable bit
	always_comb begin
		rx_accept = 1'b1;
		if (top_reg.ctrl.stop_check_multiproc_enable) begin
			if (top_reg.ctrl.frame_format_select == USP_FMT_9BIT) begin
				rx_accept = rx_frame.ninth; // RULE_03
			end else begin
				rx_accept = rx_frame.stop; // RULE_02
			end
		end
	end

	assign ctrl_wr = sfr_req.wr && sfr_req.addr == USP_CTRL_ADDR;
	assign tx_end = top_reg.tx_st == USP_TX_STOP && baud_tick &&
		top_reg.tcnt == USP_TICKS_LAST;

	// ==========================================================
	// Control, transmitter and flags
	always_comb begin
		top_next = top_reg;
		top_next.rx_valid = 1'b0;
		// Pin filter: a new level counts once the two later stages agree
		top_next.rx_sync = {top_reg.rx_sync[1:0], rx_pin};
		if (top_reg.rx_sync[1] == top_reg.rx_sync[2]) begin
			top_next.rx_level = top_reg.rx_sync[2];
		end

		// Software write first so hardware events below override it
		if (ctrl_wr) begin
			top_next.ctrl = usp_ctrl_s'(sfr_req.wdata);
			top_next.ctrl.unused = USP_UNUSED_LEVEL;
		end

		if (rx_done) begin
			if (top_reg.ctrl.frame_format_select == USP_FMT_9BIT) begin
				top_next.ctrl.receive_ninth_bit = rx_frame.ninth; // RULE_07
			end else begin
				top_next.ctrl.receive_ninth_bit = rx_frame.stop; // RULE_07
			end
			if (rx_accept) begin
				top_next.ctrl.receive_complete_flag = 1'b1; // RULE_08
				top_next.rx_data = rx_frame.data;
				top_next.rx_valid = 1'b1;
			end
		end

		if (baud_tick && top_reg.tx_st != USP_TX_IDLE) begin
			top_next.tcnt = top_reg.tcnt + 4'h1;
		end
		case (top_reg.tx_st)
			USP_TX_IDLE: begin
				top_next.txd = 1'b1;
				top_next.tcnt = 4'h0;
				if (tx_start) begin
					top_next.tx_shift = tx_data;
					top_next.busy = 1'b1;
					top_next.txd = 1'b0;
					top_next.tx_st = USP_TX_START;
				end
			end
			USP_TX_START: begin
				if (baud_tick && top_reg.tcnt == USP_TICKS_LAST) begin
					top_next.txd = top_reg.tx_shift[0];
					top_next.bcnt = 4'h0;
					top_next.tx_st = USP_TX_DATA;
				end
			end
			USP_TX_DATA: begin
				if (baud_tick && top_reg.tcnt == USP_TICKS_LAST) begin
					top_next.tx_shift = {1'b0, top_reg.tx_shift[7:1]};
					top_next.bcnt = top_reg.bcnt + 4'h1;
					top_next.txd = top_reg.tx_shift[1];
					if (top_reg.bcnt == USP_LAST_DATA_BIT) begin
						if (top_reg.ctrl.frame_format_select == USP_FMT_9BIT) begin
							// Read only, never written back
							top_next.txd = top_reg.ctrl.transmit_ninth_bit; // RULE_05
							top_next.tx_st = USP_TX_NINTH;
						end else begin
							// Ninth bit is not consulted at all here
							top_next.txd = 1'b1; // RULE_06
							top_next.tx_st = USP_TX_STOP;
							top_next.ctrl.transmit_complete_flag = 1'b1; // RULE_08
						end
					end
				end
			end
			USP_TX_NINTH: begin
				if (baud_tick && top_reg.tcnt == USP_TICKS_LAST) begin
					top_next.txd = 1'b1;
					top_next.tx_st = USP_TX_STOP;
					top_next.ctrl.transmit_complete_flag = 1'b1; // RULE_08
				end
			end
			USP_TX_STOP: begin
				if (tx_end) begin
					top_next.busy = 1'b0;
					top_next.tx_st = USP_TX_IDLE;
				end
			end
			default: begin
				top_next.tx_st = USP_TX_IDLE;
				top_next.busy = 1'b0;
				top_next.txd = 1'b1;
			end
		endcase

		// Reads show the register as it stood before this cycle's write,
		// so the core may read and write in one cycle
		top_next.rdata = 8'h00;
		if (sfr_req.addr == USP_CTRL_ADDR) begin
			top_next.rdata = top_reg.ctrl;
		end
		top_next.irq = port_int_enable &&
			(top_next.ctrl.transmit_complete_flag ||
			top_next.ctrl.receive_complete_flag); // RULE_08
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			top_reg <= '0;
			top_reg.rx_sync <= 3'h7;
			top_reg.rx_level <= 1'b1;
			top_reg.ctrl <= usp_ctrl_s'(USP_CTRL_RESET);
			top_reg.txd <= 1'b1;
		end else begin
			top_reg <= top_next;
		end
	end

	assign sfr_rdata = top_reg.rdata;
	assign tx_busy = top_reg.busy;
	assign tx_pin = top_reg.txd;
	assign rx_data = top_reg.rx_data;
	assign rx_data_valid = top_reg.rx_valid;
	assign port_irq = top_reg.irq;

endmodule : usp_serial_port_two

`default_nettype wire

// *** sim/usp_serial_port_two_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module usp_serial_port_two_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire usp_pkg::usp_sfr_req_s sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic tx_start,
	input wire logic tx_busy,
	input wire logic tx_pin,
	input wire logic [7:0] rx_data,
	input wire logic rx_data_valid,
	input wire logic port_int_enable,
	input wire logic port_irq
);
	import usp_pkg::*;
	// ==========================================================
	// Checks gated by live_reg[3] are held off for four edges after reset
	logic [3:0] live_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			live_reg <= 4'h0;
		end else begin
			live_reg <= {live_reg[2:0], 1'b1};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Properties
	chk_unused_one: assert property (live_reg[3] &&
		$past(sfr_req.addr) == USP_CTRL_ADDR |-> sfr_rdata[6])
		else $error("unused bit not one");
	chk_unmapped_zero: assert property (live_reg[3] &&
		$past(sfr_req.addr) != USP_CTRL_ADDR |-> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_irq_off: assert property (!port_int_enable |=> !port_irq)
		else $error("irq while disabled");
	chk_irq_rx: assert property (rx_data_valid && port_int_enable
		|-> ##[0:2] port_irq) else $error("no irq after receive");
	chk_tx_accept: assert property (live_reg[3] && tx_start &&
		!tx_busy |=> tx_busy && !tx_pin) else $error("start not taken");
	chk_start_width: assert property ($rose(tx_busy)
		|-> !tx_pin [*8]) else $error("start bit too short");
	chk_idle_high: assert property (live_reg[3] && !tx_busy
		|-> tx_pin) else $error("line not idle high");
	chk_rx_update: assert property (live_reg[3] && $changed(rx_data)
		|-> rx_data_valid) else $error("data changed without frame");
endmodule : usp_serial_port_two_asserts

bind usp_serial_port_two usp_serial_port_two_asserts i_chk (
	.mclk(mclk),
	.rst_n(rst_n),
	.sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata),
	.tx_start(tx_start),
	.tx_busy(tx_busy),
	.tx_pin(tx_pin),
	.rx_data(rx_data),
	.rx_data_valid(rx_data_valid),
	.port_int_enable(port_int_enable),
	.port_irq(port_irq)
);

`default_nettype wire

// *** sim/usp_peer.sv ***
`timescale 1ns/1ps
`default_nettype none

// Remote sender: shifts a frame LSB first, 16 ticks a bit
module usp_peer (
	input wire logic mclk,
	input wire logic baud_tick,
	input wire logic go,
	input wire logic [10:0] frame,
	input wire logic [3:0] nbits,
	output logic rx_pin,
	output logic busy
);
	logic [10:0] sh_reg;
	logic [3:0] left_reg;
	logic [3:0] tick_reg;
	initial busy = 1'b0;
	always @(posedge mclk) begin
		if (go && !busy) begin
			sh_reg <= frame;
			left_reg <= nbits;
			tick_reg <= 4'h0;
			busy <= 1'b1;
		end else if (busy && baud_tick) begin
			tick_reg <= tick_reg + 4'h1;
			if (tick_reg == 4'hF) begin
				sh_reg <= {1'b1, sh_reg[10:1]};
				left_reg <= left_reg - 4'h1;
				busy <= (left_reg != 4'h1);
			end
		end
	end
	// Idle line rests at its pulled-up level
	assign rx_pin = busy ? sh_reg[0] : 1'b1;
endmodule : usp_peer

`default_nettype wire

// *** sim/usp_serial_port_two_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module usp_serial_port_two_tb_top;
	import usp_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	usp_sfr_req_s sfr_req = '0;
	logic [7:0] sfr_rdata, rx_data, tx_data = 8'h00;
	logic baud_tick = 1'b0, tx_start = 1'b0, port_int_enable = 1'b1;
	logic tx_busy, tx_pin, rx_pin, rx_data_valid, port_irq, peer_busy;
	logic go = 1'b0;
	logic [10:0] frame = '1;
	logic [3:0] nbits = 4'h0;
	int n_fail = 0, checked = 0, cyc = 0;
	logic [7:0] ctl [7] = '{8'h10, 8'h30, 8'h30, 8'hB0, 8'hB0, 8'h90, 8'h80};
	logic [7:0] ex [7] = '{8'h51, 8'h70, 8'h75, 8'hF0, 8'hF5, 8'hD1, 8'hC0};
	logic sv [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [7:0] tc [3] = '{8'h88, 8'h80, 8'h00};

	usp_serial_port_two i_dut (.mclk(mclk), .rst_n(rst_n),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .baud_tick(baud_tick),
		.tx_start(tx_start), .tx_data(tx_data), .tx_busy(tx_busy),
		.tx_pin(tx_pin), .rx_pin(rx_pin), .rx_data(rx_data),
		.rx_data_valid(rx_data_valid), .port_int_enable(port_int_enable),
		.port_irq(port_irq));
	usp_peer i_peer (.mclk(mclk), .baud_tick(baud_tick), .go(go),
		.frame(frame), .nbits(nbits), .rx_pin(rx_pin), .busy(peer_busy));

	// ==========================================================
	// Clock, tick every second cycle, hang limit
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		baud_tick <= ~baud_tick;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			finish_test();
		end
	end

	// ==========================================================
	// Tasks
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_req <= '{1'b1, a, d};
		@(posedge mclk);
		sfr_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		sfr_req.addr <= a;
		repeat (2) @(posedge mclk);
		#1 check(sfr_rdata, exp);
	endtask : rd
	task automatic rx_frame(input logic [10:0] f, input logic [3:0] n);
		@(posedge mclk);
		frame <= f;
		nbits <= n;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		while (peer_busy) @(posedge mclk);
		repeat (6) @(posedge mclk);
	endtask : rx_frame
	// Samples each bit slot near its middle
	task automatic tx_frame(input logic [7:0] d, input logic b9,
		input logic bz);
		int i;
		@(posedge mclk);
		tx_start <= 1'b1;
		tx_data <= d;
		@(posedge mclk);
		tx_start <= 1'b0;
		repeat (16) @(posedge mclk);
		for (i = 0; i < 11; i++) begin
			#1 check({7'h0, tx_pin}, {7'h0, (i == 0) ? 1'b0 :
				(i < 9) ? d[i-1] : (i == 9) ? b9 : 1'b1});
			if (i == 10) check({7'h0, tx_busy}, {7'h0, bz});
			repeat (32) @(posedge mclk);
		end
		while (tx_busy) @(posedge mclk);
	endtask : tx_frame
	task automatic finish_test;
		if (n_fail == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// Sequence
	initial begin
		int i;
		logic [7:0] d;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(USP_CTRL_ADDR, USP_CTRL_RESET);
		wr(8'h99, 8'hFF);
		rd(8'h99, 8'h00);
		rd(USP_CTRL_ADDR, 8'h40);
		for (i = 0; i < 7; i++) begin
			@(posedge mclk);
			port_int_enable <= ctl[i][4];
			wr(USP_CTRL_ADDR, ctl[i]);
			d = 8'h96 ^ 8'(i);
			rx_frame({1'b1, sv[i], d, 1'b0}, ctl[i][7] ? 4'hB : 4'hA);
			rd(USP_CTRL_ADDR, ex[i]);
			check({7'h0, port_irq}, {7'h0, ex[i][0]});
			if (ex[i][0]) check(rx_data, d);
		end
		for (i = 0; i < 3; i++) begin
			wr(USP_CTRL_ADDR, tc[i]);
			tx_frame(8'h3C ^ 8'(i * 17), tc[i][7] ? tc[i][3] : 1'b1,
				tc[i][7]);
			rd(USP_CTRL_ADDR, tc[i] | 8'h42);
		end
		finish_test();
	end
endmodule : usp_serial_port_two_tb_top

`default_nettype wire
